// [tcs_pkg.sv]
// Package for the tandem-connection trail sink: constants, state types,
// carrier structs, plus the small frame-persistence filter module.
// Assumes one byte-rate strobe and a frame-start flag on the path input.
package tcs_pkg;
  // Byte positions inside the path frame, counted from the frame-start byte
  localparam logic [11:0] EM_IDX = 12'h002;
  localparam logic [11:0] NR_IDX = 12'h005;
  // Bit positions of the overhead byte; bit 1 is the MSB, bit 8 the LSB
  localparam int BIT_REI = 3;
  localparam int BIT_OEI = 2;
  localparam int BIT_MF7 = 1;
  localparam int BIT_MF8 = 0;
  // Multiframe layout
  localparam logic [6:0] MF_LEN = 7'h4C;
  localparam logic [6:0] MF_FAS_END = 7'h08;
  localparam logic [6:0] MF_TTI_FIRST = 7'h09;
  localparam logic [6:0] MF_TTI_LAST = 7'h48;
  localparam logic [6:0] MF_RDI = 7'h49;
  localparam logic [6:0] MF_ODI = 7'h4A;
  localparam logic [11:0] FAS_PATTERN = 12'hFFE;
  localparam int TTI_BITS = 128;
  // Error code handling
  localparam logic [3:0] IEC_MAX = 4'h8;
  localparam logic [3:0] IEC_ALARM = 4'hE;
  localparam logic [7:0] NR_UNEQ = 8'h00;
  localparam logic [7:0] NR_ZERO = 8'h00;
  // Persistence filter length in frames
  localparam logic [2:0] PERSIST_FRAMES = 3'h5;
  // Reset value and the frame-start count that ends priming
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] PRIME_DONE = 2'h2;

  // Multiframe aligner states
  typedef enum logic [1:0] {
    ALIGN_OOM = 2'b01,
    ALIGN_IM = 2'b10
  } tcs_align_e;

  // Path stream carrier: byte strobe, frame start, data
  typedef struct packed {
    logic valid;
    logic fs;
    logic [7:0] data;
  } tcs_path_s;

  // Per-frame one-cycle indications
  typedef struct packed {
    logic tick;
    logic erroredTcBlock;
    logic erroredPathBlock;
    logic farErroredBlock;
    logic farOutgoingErroredBlock;
  } tcs_mon_s;

  // Level defects held in the main state
  typedef struct packed {
    logic tcLossDefect;
    logic traceMismatchDefect;
    logic remoteDefectInd;
    logic outgoingDefectInd;
  } tcs_def_s;

  // Persistence filter state
  typedef struct packed {
    logic [2:0] cnt;
    logic defect;
  } tcs_persist_s;
endpackage

`timescale 1ns/1ps
`default_nettype none
// Five-frame persistence filter: state follows cond after 5 equal frames
module tcs_persist
  import tcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic cond,
  output logic defect
);
  tcs_persist_s s_q; // Filter state
  tcs_persist_s s_d; // Next filter state

  // Count frames that disagree with the present state
  always_comb
  begin
    s_d = s_q;
    if (tick)
    begin
      if (cond != s_q.defect)
      begin
        s_d.cnt = s_q.cnt + 3'h1;
        // Fifth disagreeing frame flips the defect
        if (s_d.cnt == PERSIST_FRAMES)
        begin
          s_d.defect = cond;
          s_d.cnt = 3'h0;
        end
      end
      else
      begin
        s_d.cnt = 3'h0;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign defect = s_q.defect;
endmodule
`default_nettype wire

// [tcs_trail_sink.sv]
// Tandem-connection trail termination sink for a framed path signal.
// Assumes the path strobe and frame start are on sys_clk, one byte a strobe.
`timescale 1ns/1ps
`default_nettype none
module tcs_trail_sink
  import tcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire tcs_path_s pathIn,
  input wire logic serverSignalFail,
  input wire logic traceMismatchDisable,
  input wire logic [TTI_BITS-1:0] expectedTraceId,
  output tcs_path_s pathOut,
  output tcs_mon_s mon,
  output tcs_def_s defects,
  output logic unequippedDefect,
  output logic incomingAlarmDefect,
  output logic [TTI_BITS-1:0] acceptedTraceId
);
  // Main state of the sink; the two persistence filters keep their own
  typedef struct packed {
    tcs_path_s pathOut;
    logic [11:0] byteIdx;
    logic [1:0] primed;
    logic [7:0] parAcc;
    logic [7:0] parPrev;
    logic [7:0] emRx;
    logic [7:0] nrRx;
    logic [7:0] nrPrevFrame;
    logic [7:0] emOrigPrev;
    logic [7:0] emNewPrev;
    tcs_align_e align;
    logic fasErr1;
    logic [6:0] mfCnt;
    logic [15:0] fasSh;
    logic [TTI_BITS-1:0] ttiShift;
    logic [TTI_BITS-1:0] ttiLast;
    logic [TTI_BITS-1:0] accepted_trace_id;
    tcs_mon_s mon;
    tcs_def_s def;
  } tcs_state_s;

  tcs_state_s s_q; // Registered state
  tcs_state_s s_d; // Next state

  logic [11:0] curIdx; // Index of the byte now on the input
  logic frameEnd; // Previous frame just completed
  logic [3:0] errCnt; // Parity mismatches of the completed comparison
  logic [3:0] iecDec; // Decoded incoming error count
  logic [15:0] fasShN; // Alignment bits including the completed frame
  logic [6:0] curMf; // Multiframe number of the completed frame
  logic [TTI_BITS-1:0] ttiShiftN; // Trace bits including this frame
  logic fasGood; // Last twelve alignment bits match

  // Frame timing and per-frame decode
  always_comb
  begin
    curIdx = pathIn.fs ? 12'h000 : s_q.byteIdx + 12'h001;
    frameEnd = pathIn.valid & pathIn.fs & (s_q.primed != 2'h0);
    errCnt = 4'h0;
    // Count mismatching parity positions
    for (int i = 0; i < 8; i++)
    begin
      errCnt = errCnt + {3'h0, s_q.emRx[i] ^ s_q.parPrev[i]};
    end
    // Codes nine to fifteen carry no count
    iecDec = (s_q.nrRx[7:4] <= IEC_MAX) ? s_q.nrRx[7:4] : 4'h0;
    fasShN = {s_q.fasSh[13:0], s_q.nrRx[BIT_MF7], s_q.nrRx[BIT_MF8]};
    fasGood = (fasShN[11:0] == FAS_PATTERN);
    curMf = (s_q.mfCnt >= MF_LEN) ? 7'h01 : s_q.mfCnt + 7'h01;
    ttiShiftN = {s_q.ttiShift[TTI_BITS-3:0], s_q.nrRx[BIT_MF7], s_q.nrRx[BIT_MF8]};
  end

  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.mon = '0;
    // Forward path, with only the overhead edits applied
    s_d.pathOut.valid = pathIn.valid;
    s_d.pathOut.fs = pathIn.fs;
    if (pathIn.valid)
    begin
      s_d.pathOut.data = pathIn.data;
      s_d.byteIdx = curIdx;
      // Parity of the incoming bytes, original values
      s_d.parAcc = pathIn.fs ? pathIn.data : s_q.parAcc ^ pathIn.data;
      if (pathIn.fs)
      begin
        s_d.parPrev = s_q.parAcc;
        s_d.nrPrevFrame = s_q.nrRx;
        if (s_q.primed != PRIME_DONE)
          s_d.primed = s_q.primed + 2'h1;
      end
      if (curIdx == NR_IDX)
      begin
        s_d.nrRx = pathIn.data;
        s_d.pathOut.data = NR_ZERO;
      end
      if (curIdx == EM_IDX)
      begin
        s_d.emRx = pathIn.data;
        // New value of overhead is zero, so its term drops out
        s_d.pathOut.data = s_q.emOrigPrev ^ s_q.emNewPrev ^ s_q.nrPrevFrame ^ NR_ZERO
          ^ pathIn.data;
        s_d.emOrigPrev = pathIn.data;
        s_d.emNewPrev = s_d.pathOut.data;
      end
    end
    // Per-frame work on the frame that just ended
    if (frameEnd)
    begin
      s_d.mon.tick = 1'b1;
      s_d.mon.farErroredBlock = s_q.nrRx[BIT_REI];
      s_d.mon.farOutgoingErroredBlock = s_q.nrRx[BIT_OEI];
      // Both comparisons use the frame before the ended one
      if (s_q.primed == PRIME_DONE)
      begin
        s_d.mon.erroredPathBlock = (errCnt != 4'h0);
        s_d.mon.erroredTcBlock = (errCnt != iecDec);
      end
      s_d.fasSh = fasShN;
      if (s_q.align == ALIGN_OOM)
      begin
        // Search for the pattern on any frame
        if (fasGood)
        begin
          s_d.align = ALIGN_IM;
          s_d.mfCnt = MF_FAS_END;
          s_d.fasErr1 = 1'b0;
        end
      end
      else
      begin
        s_d.mfCnt = curMf;
        // Check only at the presumed pattern end
        if (curMf == MF_FAS_END)
        begin
          s_d.fasErr1 = !fasGood;
          if (!fasGood && s_q.fasErr1)
            s_d.align = ALIGN_OOM;
        end
        // Trace bits, frames 9 to 72
        if (curMf >= MF_TTI_FIRST && curMf <= MF_TTI_LAST)
          s_d.ttiShift = ttiShiftN;
        // Accept a trace seen twice running
        if (curMf == MF_TTI_LAST)
        begin
          s_d.ttiLast = ttiShiftN;
          if (ttiShiftN == s_q.ttiLast)
            s_d.accepted_trace_id = ttiShiftN;
        end
        if (curMf == MF_RDI)
          s_d.def.remoteDefectInd = s_q.nrRx[BIT_MF8];
        if (curMf == MF_ODI)
          s_d.def.outgoingDefectInd = s_q.nrRx[BIT_MF7];
      end
    end
    // Loss defect mirrors the aligner
    s_d.def.tcLossDefect = (s_d.align == ALIGN_OOM);
    // Mismatch checked every cycle, one multiframe per update
    s_d.def.traceMismatchDefect = !traceMismatchDisable && !serverSignalFail
      && (s_q.accepted_trace_id != expectedTraceId);
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.align <= ALIGN_OOM;
      s_q.def.tcLossDefect <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Unequipped: overhead byte all zero
  tcs_persist uneqFilter (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(frameEnd),
    .cond(s_q.nrRx == NR_UNEQ),
    .defect(unequippedDefect)
  );

  // Incoming alarm code in bits 1-4
  tcs_persist alarmFilter (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(frameEnd),
    .cond(s_q.nrRx[7:4] == IEC_ALARM),
    .defect(incomingAlarmDefect)
  );

  assign pathOut = s_q.pathOut;
  assign mon = s_q.mon;
  assign defects = s_q.def;
  assign acceptedTraceId = s_q.accepted_trace_id;

  // Overhead byte leaves as zero
  nr_zeroed_a: assert property (@(posedge sys_clk) disable iff (rst)
    (pathIn.valid && curIdx == NR_IDX) |=> (pathOut.data == NR_ZERO))
    else $error("overhead byte not zeroed");

  // Other bytes pass unchanged
  path_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
    (pathIn.valid && curIdx != NR_IDX && curIdx != EM_IDX)
    |=> (pathOut.data == $past(pathIn.data) && pathOut.valid))
    else $error("path byte altered");

  // Parity mismatch raises path block flag
  path_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    (frameEnd && s_q.primed == PRIME_DONE && errCnt != 4'h0) |=> mon.erroredPathBlock)
    else $error("errored path block missed");

  // Count difference raises tc block flag
  tc_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    (frameEnd && s_q.primed == PRIME_DONE) |=> (mon.erroredTcBlock == ($past(errCnt)
    != $past(iecDec))))
    else $error("errored tc block wrong");

  // Loss entered only after two bad patterns
  oom_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.align == ALIGN_IM) ##1 (s_q.align == ALIGN_OOM) |-> $past(s_q.fasErr1))
    else $error("out of multiframe too early");

  // One good pattern realigns
  im_return_a: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.align == ALIGN_OOM && frameEnd && fasGood) |=> ##1 !defects.tcLossDefect)
    else $error("no realignment");

  // Server fail suppresses mismatch
  tim_ssf_a: assert property (@(posedge sys_clk) disable iff (rst)
    serverSignalFail |=> !defects.traceMismatchDefect)
    else $error("mismatch during server fail");

  // Disable blocks mismatch
  tim_dis_a: assert property (@(posedge sys_clk) disable iff (rst)
    traceMismatchDisable [*2] |-> ##1 !defects.traceMismatchDefect)
    else $error("mismatch while disabled");

  // Remote defect latched in frame 73
  rdi_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
    (frameEnd && s_q.align == ALIGN_IM && curMf == MF_RDI)
    |=> (defects.remoteDefectInd == $past(s_q.nrRx[BIT_MF8])))
    else $error("remote defect not latched");

  // Outgoing defect latched in frame 74
  odi_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
    (frameEnd && s_q.align == ALIGN_IM && curMf == MF_ODI)
    |=> (defects.outgoingDefectInd == $past(s_q.nrRx[BIT_MF7])))
    else $error("outgoing defect not latched");

  // Remote error bit forwarded per frame
  far_error_a: assert property (@(posedge sys_clk) disable iff (rst)
    frameEnd
    |=> (mon.farErroredBlock == $past(s_q.nrRx[BIT_REI])))
    else $error("remote error bit lost");

  // Outgoing error bit forwarded per frame
  far_out_error_a: assert property (@(posedge sys_clk) disable iff (rst)
    frameEnd
    |=> (mon.farOutgoingErroredBlock == $past(s_q.nrRx[BIT_OEI])))
    else $error("outgoing error bit lost");

  // High codes decode as no errors
  iec_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (frameEnd && s_q.primed == PRIME_DONE && s_q.nrRx[7:4] > IEC_MAX && errCnt == 4'h0)
    |=> !mon.erroredTcBlock)
    else $error("high error code counted");

  // Trace seen twice running is accepted
  tti_accept_a: assert property (@(posedge sys_clk) disable iff (rst)
    (frameEnd && s_q.align == ALIGN_IM && curMf == MF_TTI_LAST && ttiShiftN == s_q.ttiLast)
    |=> (acceptedTraceId == $past(ttiShiftN)))
    else $error("trace not accepted");
endmodule
`default_nettype wire

// [tcs_far_source.sv]
// Far-end source model: eight-byte frames, parity byte, overhead byte.
// Assumes the sink's clock and reset; sends one byte every cycle.
`timescale 1ns/1ps
`default_nettype none
module tcs_far_source
  import tcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] iec,
  input wire logic [7:0] errMask,
  input wire logic upCount,
  input wire logic nrZero,
  input wire logic [3:0] ind,
  input wire logic [TTI_BITS-1:0] trace,
  output tcs_path_s pathIn
);
  logic [2:0] idx_q; // Byte index in frame
  logic [6:0] mf_q; // Frame number in multiframe
  logic [7:0] bip_q, bipPrev_q, maskPrev_q, raw;
  logic [1:0] mfBits; // Bits 7 and 8 of this frame
  logic [3:0] code; // Error code sent
  // Overhead and payload of the current byte
  always_comb
  begin
    mfBits = 2'b00;
    if (mf_q < 7'd8)
      mfBits = 2'(16'hFFFE >> (14 - 2 * mf_q));
    else if (mf_q < 7'd72)
      mfBits = 2'(trace >> (142 - 2 * mf_q));
    else if (mf_q == 7'd72)
      mfBits = {1'b0, ind[1]};
    else if (mf_q == 7'd73)
      mfBits = {ind[0], 1'b0};
    code = (upCount && maskPrev_q != 8'h00) ? 4'($countones(maskPrev_q)) : iec;
    raw = {mf_q[4:0], idx_q};
    if (idx_q == 3'd2)
      raw = bipPrev_q;
    if (idx_q == 3'd5)
      raw = nrZero ? 8'h00 : {code, ind[3], ind[2], mfBits};
  end
  // Line errors hit only the last byte, so a mask set at frame start is whole
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      idx_q <= 3'd0;
      mf_q <= 7'd0;
      bip_q <= 8'h00;
      bipPrev_q <= 8'h00;
      maskPrev_q <= 8'h00;
      pathIn <= '0;
    end
    else
    begin
      pathIn <= '{valid: 1'b1, fs: idx_q == 3'd0, data: raw ^ (idx_q == 3'd7 ? errMask : 8'h00)};
      idx_q <= idx_q + 3'd1;
      bip_q <= (idx_q == 3'd0) ? raw : bip_q ^ raw;
      if (idx_q == 3'd7)
      begin
        bipPrev_q <= bip_q ^ raw;
        maskPrev_q <= errMask;
        mf_q <= (mf_q == MF_LEN - 7'd1) ? 7'd0 : mf_q + 7'd1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_tcs_trail_sink.sv]
// Testbench of the tandem sink: the far-end model feeds the path input.
// Assumes the model sends eight-byte frames back to back.
`timescale 1ns/1ps
`default_nettype none
module tb_tcs_trail_sink
  import tcs_pkg::*;
();
  localparam logic [TTI_BITS-1:0] TRACE = {16{8'h5A}}; // No all-zero pairs
  logic sys_clk = 1'b0;
  logic rst, upCount, nrZero, server_signal_fail, trace_mismatch_disable, uneq, alarm;
  logic [3:0] iec, ind;
  logic [7:0] errMask, expByte, emIn0, emOut0, nrIn0;
  logic [2:0] oIdx;
  logic [TTI_BITS-1:0] expTrace, acc;
  tcs_path_s pathIn, pathOut, inD;
  tcs_mon_s mon;
  tcs_def_s defects;
  int badCount = 0;
  int numChecks = 0;
  int cnt [5]; // Pulse counts: tc, path, far, far outgoing, tick
  tcs_far_source u_tcs_far_source (.sys_clk(sys_clk), .rst(rst), .iec(iec),
    .errMask(errMask), .upCount(upCount), .nrZero(nrZero), .ind(ind), .trace(TRACE),
    .pathIn(pathIn));
  tcs_trail_sink u_tcs_trail_sink (.sys_clk(sys_clk), .rst(rst), .pathIn(pathIn),
    .serverSignalFail(server_signal_fail), .traceMismatchDisable(trace_mismatch_disable), .expectedTraceId(expTrace),
    .pathOut(pathOut), .mon(mon), .defects(defects), .unequippedDefect(uneq),
    .incomingAlarmDefect(alarm), .acceptedTraceId(acc));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    numChecks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      badCount++;
    end
  endtask
  task automatic summarize();
    if (badCount == 0 && numChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Wait for n frame starts, bounded
  task automatic frames(input int n);
    int g;
    repeat (n)
    begin
      g = 0;
      do
      begin
        @(posedge sys_clk);
        g++;
      end
      while (!(pathIn.valid && pathIn.fs) && g < 20);
      if (g >= 20)
      begin
        badCount++;
        summarize();
      end
    end
  endtask
  // Settle two frames, then count three
  task automatic window();
    frames(2);
    cnt = '{default: 0};
    frames(3);
  endtask
  // Pulse counting and forwarded byte check, away from the clock edge
  always @(negedge sys_clk)
  begin
    cnt[0] += int'(mon.erroredTcBlock);
    cnt[1] += int'(mon.erroredPathBlock);
    cnt[2] += int'(mon.farErroredBlock);
    cnt[3] += int'(mon.farOutgoingErroredBlock);
    cnt[4] += int'(mon.tick);
    if (rst)
    begin
      emIn0 = 8'h00;
      emOut0 = 8'h00;
      nrIn0 = 8'h00;
    end
    else if (inD.valid)
    begin
      oIdx = inD.fs ? 3'd0 : oIdx + 3'd1;
      expByte = inD.data;
      if (oIdx == NR_IDX[2:0])
      begin
        expByte = NR_ZERO;
        nrIn0 = inD.data;
      end
      if (oIdx == EM_IDX[2:0])
      begin
        expByte = emIn0 ^ emOut0 ^ nrIn0 ^ inD.data;
        emIn0 = inD.data;
        emOut0 = expByte;
      end
      chk("pathOut", 128'({1'b1, inD.fs, expByte}), 128'(pathOut));
    end
    inD = pathIn;
  end
  task automatic timStep(input string what, input logic [3:0] exp);
    repeat (3) @(posedge sys_clk);
    chk(what, 128'(exp), 128'(defects));
  endtask
  task automatic align();
    ind <= 4'b0011;
    frames(240);
    chk("aligned", 128'(4'b0011), 128'(defects));
    chk("trace", TRACE, acc);
    expTrace <= ~TRACE;
    timStep("timOn", 4'b0111);
    trace_mismatch_disable <= 1'b1;
    timStep("trace_mismatch_disable", 4'b0011);
    trace_mismatch_disable <= 1'b0;
    server_signal_fail <= 1'b1;
    timStep("timSsf", 4'b0011);
    server_signal_fail <= 1'b0;
    expTrace <= TRACE;
    ind <= 4'b0000;
    frames(80);
    chk("indClear", 128'(4'b0000), 128'(defects));
  endtask
  task automatic iecCodes();
    for (int c = 0; c < 16; c++)
    begin
      iec <= 4'(c);
      window();
      chk("tcBlocks", 128'((c >= 1 && c <= 8) ? 3 : 0), 128'(cnt[0]));
      chk("pathBlocks", 128'(0), 128'(cnt[1]));
      chk("ticks", 128'(3), 128'(cnt[4]));
    end
    iec <= 4'h9;
  endtask
  // Reset in mid-run: outputs return to their reset values
  task automatic midReset();
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("rstDefects", 128'(4'b1000), 128'(defects));
    chk("rstFilters", 128'(2'b00), 128'({uneq, alarm}));
    chk("rstTrace", 128'(0), acc);
    chk("rstMon", 128'(0), 128'(mon));
    rst <= 1'b0;
  endtask
  task automatic parity();
    for (int u = 0; u < 2; u++)
    begin
      upCount <= u[0];
      frames(1);
      cnt = '{default: 0};
      errMask <= 8'h07;
      frames(1);
      errMask <= 8'h00;
      frames(3);
      chk("pathBlocks", 128'(1), 128'(cnt[1]));
      chk("tcBlocks", 128'(1 - u), 128'(cnt[0]));
    end
    upCount <= 1'b0;
  endtask
  task automatic far();
    for (int r = 0; r < 2; r++)
    begin
      ind <= r[0] ? 4'b0100 : 4'b1000;
      window();
      chk("farBlocks", 128'(3 - 3 * r), 128'(cnt[2]));
      chk("farOutBlocks", 128'(3 * r), 128'(cnt[3]));
    end
    ind <= 4'b0000;
  endtask
  // Raise then clear a five-frame defect; sel 0 alarm code, 1 zero byte
  task automatic persist(input int sel);
    for (int v = 1; v >= 0; v--)
    begin
      frames(1);
      if (sel == 0)
        iec <= v[0] ? IEC_ALARM : 4'h9;
      else
        nrZero <= v[0];
      frames(4);
      repeat (2) @(posedge sys_clk);
      chk("persistEarly", 128'(!v), 128'(sel ? uneq : alarm));
      frames(1);
      repeat (2) @(posedge sys_clk);
      chk("persistDone", 128'(v), 128'(sel ? uneq : alarm));
    end
  endtask
  task automatic loss();
    chk("lossStay", 128'(0), 128'(defects.tcLossDefect));
    nrZero <= 1'b1;
    frames(160);
    chk("lossOn", 128'(1), 128'(defects.tcLossDefect));
    nrZero <= 1'b0;
    frames(160);
    chk("lossOff", 128'(0), 128'(defects.tcLossDefect));
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    iec = 4'h9;
    errMask = 8'h00;
    upCount = 1'b0;
    nrZero = 1'b0;
    ind = 4'b0000;
    server_signal_fail = 1'b0;
    trace_mismatch_disable = 1'b0;
    expTrace = TRACE;
    repeat (20) @(posedge sys_clk);
    chk("resetDefects", 128'(4'b1000), 128'(defects));
    rst <= 1'b0;
    align();
    iecCodes();
    parity();
    far();
    persist(0);
    persist(1);
    loss();
    midReset();
    summarize();
  end
endmodule
`default_nettype wire
